// *** hdl/sbs_pkg.sv ***
// What this block does
// - Train link on reset release with standby and power-good high.
// - Reset lines map to links by split mode.
// - Only reset 0 trusted before split latched.
// - Card pulls open-drain wake low to restore link.
// - Wake sources share one line as wired-OR.
// - Wake only while function is in D3.
// - Wake isolated until auxiliary supply present.
// - Power-break low requests lower power state.
// - Fourth presence bit only for sixteen-lane cards.
// - Card latches split when standby and power-good high.

package sbs_pkg;

    // -------------------------------------------------------------------
    // Geometry
    // -------------------------------------------------------------------
    localparam int LINK_N = 4;
    localparam int SPLIT_W = 3;
    localparam int PRES_W = 4;
    localparam int WAKE_SRC_N = 2;

    // -------------------------------------------------------------------
    // Lane-split codes, active-high view of the latched select lines
    // -------------------------------------------------------------------
    localparam logic [SPLIT_W-1:0] SPLIT_CODE_1X16 = 3'h0;
    localparam logic [SPLIT_W-1:0] SPLIT_CODE_2X8 = 3'h1;
    localparam logic [SPLIT_W-1:0] SPLIT_CODE_4X4 = 3'h2;

    typedef enum logic [1:0] {
        SBS_SPLIT_1X16 = 2'b00,
        SBS_SPLIT_2X8 = 2'b01,
        SBS_SPLIT_4X4 = 2'b10
    } sbs_split_t;

    // -------------------------------------------------------------------
    // Presence strap and reset values
    // -------------------------------------------------------------------
    localparam int PRES_WIDE_BIT = 3;
    localparam logic [PRES_W-1:0] PRES_CODE_DEFAULT = 4'h5;
    localparam logic [PRES_W-1:0] PRES_RST = 4'hf;
    localparam logic [SPLIT_W-1:0] SPLIT_RST = 3'h0;

endpackage : sbs_pkg

// *** hdl/sbs_seq.sv ***
`timescale 1ns/1ps
`default_nettype none

module sbs_seq
    import sbs_pkg::*;
#(
    parameter logic [PRES_W-1:0] PRES_CODE = PRES_CODE_DEFAULT,
    parameter bit WIDE_CARD = 1'b1
) (
    // Clock, reset, enable
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // Power handshake pins
    input wire logic standby_rail_enable_in,
    input wire logic card_power_good_in,
    input wire logic aux_present_in,
    // Lane-split selection pins, active low
    input wire logic [SPLIT_W-1:0] lane_split_select_n_in,
    // Per-link reset pins from the baseboard, active low
    input wire logic [LINK_N-1:0] link_reset_pin_n_in,
    // Power-break pin, active low
    input wire logic power_break_n_in,
    // Open-drain wake pin
    input wire logic wake_n_in,
    output logic wake_n_out,
    output logic wake_n_oe_out,
    // Core side
    input wire logic [WAKE_SRC_N-1:0] wake_src_req_in,
    input wire logic func_in_d3_in,
    // Status toward the core
    output logic aux_mode_out,
    output logic split_valid_out,
    output logic [1:0] split_mode_out,
    output logic split_unsupported_out,
    output logic [LINK_N-1:0] link_reset_n_out,
    output logic [LINK_N-1:0] link_train_en_out,
    output logic low_power_req_out,
    output logic wake_line_low_out,
    output logic [PRES_W-1:0] presence_sense_code_out
);

    // -------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------
    logic standby_s;
    logic power_good_s;
    logic aux_present_s;
    logic [SPLIT_W-1:0] split_n_s;
    logic [LINK_N-1:0] link_reset_n_s;
    logic power_break_n_s;
    logic wake_n_s;

    sbs_sync #(.WIDTH(3), .RST_VAL(3'h0)) u_sync_pwr (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .d_in({standby_rail_enable_in, card_power_good_in, aux_present_in}),
        .q_out({standby_s, power_good_s, aux_present_s})
    );

    // Active-low pins rest at their inactive level through reset
    sbs_sync #(.WIDTH(SPLIT_W + LINK_N + 2), .RST_VAL('0)) u_sync_low (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .d_in({~lane_split_select_n_in, ~link_reset_pin_n_in,
               ~power_break_n_in, ~wake_n_in}),
        .q_out({split_n_s, link_reset_n_s, power_break_n_s, wake_n_s})
    );

    // Positive views of the inverted synchroniser outputs
    logic [SPLIT_W-1:0] split_req;
    logic [LINK_N-1:0] link_in_reset;
    logic power_break_req;
    logic wake_low;

    assign split_req = split_n_s;
    assign link_in_reset = link_reset_n_s;
    assign power_break_req = power_break_n_s;
    assign wake_low = wake_n_s;

    // -------------------------------------------------------------------
    // Auxiliary power mode and split latch
    // -------------------------------------------------------------------
    logic aux_mode_next;
    logic split_valid_reg;
    logic [SPLIT_W-1:0] split_code_reg;

    assign aux_mode_next = standby_s && power_good_s;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            aux_mode_out <= 1'b0;
        end else if (ce_in) begin
            aux_mode_out <= aux_mode_next;
        end
    end

    // Captured once on entry to aux mode; the lines are ignored after
    // that until standby drops, so a late glitch cannot re-split lanes.
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            split_valid_reg <= 1'b0;
            split_code_reg <= SPLIT_RST;
        end else if (ce_in) begin
            if (!standby_s) begin
                split_valid_reg <= 1'b0;
                split_code_reg <= SPLIT_RST;
            end else if (aux_mode_next && !split_valid_reg) begin
                split_valid_reg <= 1'b1;
                split_code_reg <= split_req;
            end
        end
    end

    assign split_valid_out = split_valid_reg;

    // -------------------------------------------------------------------
    // Split decode
    // -------------------------------------------------------------------
    sbs_split_t split_mode_next;
    logic split_bad_next;

    // Unknown codes fall back to one wide link on reset 0 only
    always_comb begin
        split_mode_next = SBS_SPLIT_1X16;
        split_bad_next = 1'b0;
        if (split_valid_reg) begin
            if (split_code_reg == SPLIT_CODE_2X8) begin
                split_mode_next = SBS_SPLIT_2X8;
            end else if (split_code_reg == SPLIT_CODE_4X4) begin
                split_mode_next = SBS_SPLIT_4X4;
            end else if (split_code_reg != SPLIT_CODE_1X16) begin
                split_bad_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            split_mode_out <= SBS_SPLIT_1X16;
            split_unsupported_out <= 1'b0;
        end else if (ce_in) begin
            split_mode_out <= split_mode_next;
            split_unsupported_out <= split_bad_next;
        end
    end

    // -------------------------------------------------------------------
    // Link reset mapping
    // -------------------------------------------------------------------
    logic [LINK_N-1:0] link_used;

    always_comb begin
        link_used = 4'h1;
        unique case (split_mode_next)
            SBS_SPLIT_1X16: link_used = 4'h1;
            SBS_SPLIT_2X8: link_used = 4'h3;
            SBS_SPLIT_4X4: link_used = 4'hf;
            default: link_used = 4'h1;
        endcase
    end

    // Unused links stay in reset whatever their pin does
    for (genvar i = 0; i < LINK_N; i++) begin : g_link
        always_ff @(posedge clock_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                link_reset_n_out[i] <= 1'b0;
                link_train_en_out[i] <= 1'b0;
            end else if (ce_in) begin
                link_reset_n_out[i] <= link_used[i] && !link_in_reset[i];
                // Training also needs aux mode (standby and power good high), not release alone
                link_train_en_out[i] <= link_used[i] && !link_in_reset[i]
                                        && aux_mode_next;
            end
        end
    end

    // -------------------------------------------------------------------
    // Power break
    // -------------------------------------------------------------------
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            low_power_req_out <= 1'b0;
        end else if (ce_in) begin
            low_power_req_out <= power_break_req;
        end
    end

    // -------------------------------------------------------------------
    // Wake
    // -------------------------------------------------------------------
    sbs_wake_if wake_bus ();

    assign wake_bus.src_req = wake_src_req_in;
    assign wake_bus.in_d3 = func_in_d3_in;
    assign wake_bus.aux_ok = aux_present_s;

    sbs_wake u_wake (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .wake(wake_bus.gen)
    );

    // Open drain: the data level is always low, only the enable moves
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wake_n_out <= 1'b0;
            wake_n_oe_out <= 1'b0;
        end else if (ce_in) begin
            wake_n_out <= 1'b0;
            wake_n_oe_out <= wake_bus.pull;
        end
    end

    // Any source on the shared line counts, ours or another chip's
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wake_line_low_out <= 1'b0;
        end else if (ce_in) begin
            wake_line_low_out <= wake_low;
        end
    end

    // -------------------------------------------------------------------
    // Presence strap
    // -------------------------------------------------------------------
    // Narrow cards leave the fourth bit open so it reads as absent
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            presence_sense_code_out <= PRES_RST;
        end else if (ce_in) begin
            presence_sense_code_out <= PRES_CODE;
            if (!WIDE_CARD) begin
                presence_sense_code_out[PRES_WIDE_BIT] <= 1'b1;
            end
        end
    end

endmodule : sbs_seq

`default_nettype wire

// *** hdl/sbs_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module sbs_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // Data
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);

    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;

    // -------------------------------------------------------------------
    // Per-bit three-stage chain; a change counts once stages 2 and 3 agree
    // -------------------------------------------------------------------
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clock_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                s1_reg[i] <= RST_VAL[i];
                s2_reg[i] <= RST_VAL[i];
                s3_reg[i] <= RST_VAL[i];
                q_out[i] <= RST_VAL[i];
            end else if (ce_in) begin
                s1_reg[i] <= d_in[i];
                s2_reg[i] <= s1_reg[i];
                s3_reg[i] <= s2_reg[i];
                if (s2_reg[i] == s3_reg[i]) begin
                    q_out[i] <= s3_reg[i];
                end
            end
        end
    end

endmodule : sbs_sync

`default_nettype wire

// *** hdl/sbs_wake.sv ***
`timescale 1ns/1ps
`default_nettype none

module sbs_wake
    import sbs_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // Wake sources and gating
    sbs_wake_if.gen wake
);

    // -------------------------------------------------------------------
    // Wake pull-down
    // -------------------------------------------------------------------
    // Sources are merged inside so the pin is driven from one flop; the
    // pin stays undriven while aux is absent, isolating the host.
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wake.pull <= 1'b0;
        end else if (ce_in) begin
            wake.pull <= (|wake.src_req)
                         && wake.in_d3
                         && wake.aux_ok;
        end
    end

endmodule : sbs_wake

`default_nettype wire

// *** hdl/sbs_wake_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface sbs_wake_if;
    import sbs_pkg::*;
    logic [WAKE_SRC_N-1:0] src_req;
    logic in_d3;
    logic aux_ok;
    logic pull;

    modport seq (output src_req, output in_d3, output aux_ok, input pull);
    modport gen (input src_req, input in_d3, input aux_ok, output pull);
endinterface : sbs_wake_if

`default_nettype wire

// *** sim/sbs_host_mdl.sv ***
`timescale 1ns/1ps
`default_nettype none

module sbs_host_mdl
    import sbs_pkg::*;
#(
    parameter int PG_DLY = 6,
    parameter int RST_DLY = 20,
    parameter bit LARGE_SLOT = 1'b1
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Test controls
    input wire logic power_on_in,
    input wire logic ready_in,
    input wire logic bad_split_in,
    input wire logic [SPLIT_W-1:0] split_code_in,
    input wire logic [PRES_W-1:0] presence_in,
    // Pins toward the card
    output logic standby_out,
    output logic power_good_out,
    output logic [SPLIT_W-1:0] split_n_out,
    output logic [LINK_N-1:0] link_rst_n_out,
    output logic card_seen_out,
    // Secondary connector straps and the shared wake line
    input wire logic [PRES_W-1:0] sec_presence_in,
    output logic [2*PRES_W-1:0] card_type_out,
    input wire logic wake_line_in,
    output logic [1:0] node_wake_out
);
    int cnt_reg;
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_reg <= 0;
        end else if (!power_on_in) begin
            cnt_reg <= 0;
        end else if (cnt_reg < PG_DLY + RST_DLY) begin
            cnt_reg <= cnt_reg + 1;
        end
    end
    assign standby_out = power_on_in;
    assign power_good_out = power_on_in && cnt_reg >= PG_DLY;
    // Lines low until standby rises, then the code; flipped only when a test asks
    assign split_n_out = standby_out ? (~split_code_in ^ {SPLIT_W{bad_split_in}}) : 3'h0;
    // Wait shortened from one second; reference clocks assumed stable by then
    assign link_rst_n_out = {LINK_N{ready_in && cnt_reg >= PG_DLY + RST_DLY}};
    // Only the primary connector straps are read
    assign card_seen_out = presence_in != 4'hf;
    // Type word: the secondary straps count only in a large slot
    assign card_type_out = {(LARGE_SLOT ? sec_presence_in : 4'hf), presence_in};
    logic wake_s1_reg;
    logic wake_s2_reg;
    // Line idles high on its pull-up, so the chain resets high
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wake_s1_reg <= 1'b1;
            wake_s2_reg <= 1'b1;
        end else begin
            wake_s1_reg <= wake_line_in;
            wake_s2_reg <= wake_s1_reg;
        end
    end
    // Every attached node is woken by the one card line
    assign node_wake_out = {2{!wake_s2_reg}};
endmodule : sbs_host_mdl

`default_nettype wire

// *** sim/sbs_seq_chk.sv ***
`timescale 1ns/1ps
`default_nettype none

module sbs_seq_chk
    import sbs_pkg::*;
#(
    parameter logic [PRES_W-1:0] PRES_CODE = PRES_CODE_DEFAULT,
    parameter bit WIDE_CARD = 1'b1
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // Pins and core inputs
    input wire logic standby_rail_enable_in,
    input wire logic card_power_good_in,
    input wire logic aux_present_in,
    input wire logic [LINK_N-1:0] link_reset_pin_n_in,
    input wire logic power_break_n_in,
    input wire logic [WAKE_SRC_N-1:0] wake_src_req_in,
    input wire logic func_in_d3_in,
    // Outputs watched
    input wire logic wake_n_out,
    input wire logic wake_n_oe_out,
    input wire logic aux_mode_out,
    input wire logic split_valid_out,
    input wire logic [1:0] split_mode_out,
    input wire logic [LINK_N-1:0] link_reset_n_out,
    input wire logic [LINK_N-1:0] link_train_en_out,
    input wire logic low_power_req_out,
    input wire logic [PRES_W-1:0] presence_sense_code_out
);
    default clocking @(posedge clock_in); endclocking
    // Frozen cycles hold every output, so nothing is judged then
    default disable iff (!rst_n_in || !ce_in);
    logic [LINK_N-1:0] lmask;
    assign lmask = (split_mode_out == SBS_SPLIT_4X4) ? 4'hf :
                   (split_mode_out == SBS_SPLIT_2X8) ? 4'h3 : 4'h1;
    // -------------------------------------------------------------------
    // Properties
    // -------------------------------------------------------------------
    a_wake_drives_low: assert property (wake_n_oe_out |-> !wake_n_out)
        else $error("wake driven high");
    a_wake_any_src: assert property (
        (wake_src_req_in != 0 && func_in_d3_in && aux_present_in)[*8] |-> wake_n_oe_out)
        else $error("wake source not forwarded");
    a_wake_d3_gate: assert property (wake_n_oe_out |-> $past(func_in_d3_in, 2))
        else $error("wake outside D3");
    a_wake_aux_gate: assert property ((!aux_present_in)[*8] |-> !wake_n_oe_out)
        else $error("wake without aux supply");
    a_link_reset_hold: assert property (
        (link_reset_pin_n_in == 0)[*7] |-> link_reset_n_out == 0)
        else $error("link released while pin low");
    a_train_after_rst: assert property (
        link_train_en_out == (link_reset_n_out & {LINK_N{aux_mode_out}}))
        else $error("training outside released main power");
    a_link_mode_mask: assert property (
        split_valid_out[*3] |-> (link_reset_n_out & ~lmask) == 0)
        else $error("unused link released");
    a_link0_only: assert property (
        (!split_valid_out)[*3] |-> link_reset_n_out[3:1] == 3'h0)
        else $error("link above 0 before latch");
    a_split_stays: assert property (split_valid_out[*3] |-> $stable(split_mode_out))
        else $error("split mode moved after latch");
    a_aux_mode_lvl: assert property (
        $stable({standby_rail_enable_in, card_power_good_in})[*7]
        |-> aux_mode_out == (standby_rail_enable_in && card_power_good_in))
        else $error("aux mode wrong");
    a_power_break: assert property (
        $stable(power_break_n_in)[*7] |-> low_power_req_out == !power_break_n_in)
        else $error("power break wrong");
    a_presence_code: assert property (
        $past(rst_n_in) |-> presence_sense_code_out ==
        (WIDE_CARD ? PRES_CODE : (PRES_CODE | 4'h8)))
        else $error("presence code wrong");
endmodule : sbs_seq_chk

bind sbs_seq sbs_seq_chk #(.PRES_CODE(PRES_CODE), .WIDE_CARD(WIDE_CARD)) sbs_seq_chk_i (
    .clock_in, .rst_n_in, .ce_in, .standby_rail_enable_in, .card_power_good_in, .aux_present_in,
    .link_reset_pin_n_in, .power_break_n_in, .wake_src_req_in, .func_in_d3_in, .wake_n_out,
    .wake_n_oe_out, .aux_mode_out, .split_valid_out, .split_mode_out, .link_reset_n_out,
    .link_train_en_out, .low_power_req_out, .presence_sense_code_out);

`default_nettype wire

// *** sim/test_sbs_seq.sv ***
`timescale 1ns/1ps
`default_nettype none

module test_sbs_seq;
    import sbs_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, pwr_on = 1'b0, ready = 1'b0, bad_split = 1'b0;
    logic aux = 1'b1, pb_n = 1'b1, ext_pull = 1'b0, d3 = 1'b0, seen, wline_in;
    logic [2:0] code = 3'h0;
    logic [1:0] src = 2'h0;
    logic stby, pg, wn, oe, auxm, valid, unsup, lowp, wline;
    logic [2:0] split_n;
    logic [1:0] mode;
    logic [3:0] prst, lrst, train, pres;
    logic [1:0] nodes;
    logic [7:0] ctype;
    int failures = 0;
    int check_count = 0;
    int cyc = 0;
    // Pulled up; any party may pull it low
    assign wline_in = !(oe || ext_pull);

    sbs_host_mdl sbs_host_mdl_i (.clock_in(clk), .rst_n_in(rst_n), .power_on_in(pwr_on),
        .ready_in(ready), .bad_split_in(bad_split), .split_code_in(code), .presence_in(pres),
        .standby_out(stby), .power_good_out(pg), .split_n_out(split_n), .link_rst_n_out(prst),
        .card_seen_out(seen), .sec_presence_in(pres), .card_type_out(ctype),
        .wake_line_in(wline_in), .node_wake_out(nodes));
    sbs_seq sbs_seq_i (.clock_in(clk), .rst_n_in(rst_n), .ce_in(ce),
        .standby_rail_enable_in(stby), .card_power_good_in(pg), .aux_present_in(aux),
        .lane_split_select_n_in(split_n), .link_reset_pin_n_in(prst), .power_break_n_in(pb_n),
        .wake_n_in(wline_in), .wake_n_out(wn), .wake_n_oe_out(oe), .wake_src_req_in(src),
        .func_in_d3_in(d3), .aux_mode_out(auxm), .split_valid_out(valid), .split_mode_out(mode),
        .split_unsupported_out(unsup), .link_reset_n_out(lrst), .link_train_en_out(train),
        .low_power_req_out(lowp), .wake_line_low_out(wline), .presence_sense_code_out(pres));

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    task automatic power_cycle(input logic [2:0] c, input logic [1:0] m, input logic u);
        int n;
        logic [3:0] mk;
        mk = (m == 2'h2) ? 4'hf : (m == 2'h1) ? 4'h3 : 4'h1;
        code = c;
        pwr_on = 1'b1;
        ready = 1'b1;
        for (n = 0; valid !== 1'b1 && n < 100; n++) step(1);
        chk("split_valid", 8'h1, 8'(valid));
        for (n = 0; lrst[0] !== 1'b1 && n < 100; n++) step(1);
        chk("aux_mode", 8'h1, 8'(auxm));
        chk("split_mode", 8'(m), 8'(mode));
        chk("unsupported", 8'(u), 8'(unsup));
        chk("link_reset", 8'(mk), 8'(lrst));
        chk("train_en", 8'(mk), 8'(train));
        bad_split = 1'b1;
        step(10);
        chk("mode_held", 8'(m), 8'(mode));
        bad_split = 1'b0;
        pwr_on = 1'b0;
        ready = 1'b0;
        step(10);
        chk("valid_clear", 8'h0, 8'(valid));
        chk("link_reset_off", 8'h0, 8'(lrst));
    endtask : power_cycle

    initial begin
        forever #5 clk = ~clk;
    end
    // A healthy run needs under 1500 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            failures++;
            report_and_stop();
        end
    end

    initial begin
        logic [3:0] w [6];
        w = '{4'b0111, 4'b1011, 4'b1111, 4'b0101, 4'b0110, 4'b0011};
        step(10);
        rst_n = 1'b1;
        step(3);
        chk("presence", 8'(PRES_CODE_DEFAULT), 8'(pres));
        chk("card_seen", 8'h1, 8'(seen));
        chk("card_type", {PRES_CODE_DEFAULT, PRES_CODE_DEFAULT}, ctype);
        chk("valid_idle", 8'h0, 8'(valid));
        for (int i = 0; i < 4; i++) begin
            power_cycle((i == 3) ? 3'h7 : 3'(i), (i == 3) ? 2'h0 : 2'(i), i == 3);
        end
        // Enable low freezes the chain, so the request waits for it
        ce = 1'b0;
        pb_n = 1'b0;
        step(8);
        chk("low_power_frozen", 8'h0, 8'(lowp));
        ce = 1'b1;
        step(8);
        chk("low_power", 8'h1, 8'(lowp));
        pb_n = 1'b1;
        step(8);
        chk("low_power_off", 8'h0, 8'(lowp));
        for (int i = 0; i < 6; i++) begin
            src = (i < 3) ? w[i][3:2] : ((i == 5) ? 2'h0 : 2'h1);
            d3 = (i == 3) ? 1'b0 : 1'b1;
            aux = (i == 4) ? 1'b0 : 1'b1;
            // Losing aux may let a short pull through before it syncs
            step(12);
            chk("wake_oe", 8'(i < 3), 8'(oe));
            chk("wake_drive", 8'h0, 8'(wn));
            chk("wake_seen", 8'(i < 3), 8'(wline));
        end
        ext_pull = 1'b1;
        step(8);
        chk("wake_other_src", 8'h1, 8'(wline));
        chk("node_wake", 8'h3, 8'(nodes));
        ext_pull = 1'b0;
        step(8);
        chk("node_wake_off", 8'h0, 8'(nodes));
        report_and_stop();
    end
endmodule : test_sbs_seq

`default_nettype wire
